//--- hdl/input_sync3.sv
// three-stage synchroniser for a level arriving from outside the bus clock domain
// assumes the level stays put long enough to be seen twice in a row
`timescale 1ns/100ps
`default_nettype none
module input_sync3 (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_async,
  output logic o_level
);

  logic meta_q;
  logic mid_q;
  logic late_q;
  logic level_q;
  logic level_d;

  // a change counts only once the second and third stages agree
  always_comb begin
    level_d = (mid_q == late_q) ? late_q : level_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      mid_q <= 1'b0;
      late_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      mid_q <= meta_q;
      late_q <= mid_q;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;

endmodule : input_sync3
`default_nettype wire

//--- hdl/pll_wait_clock_monitor_ctrl.sv
// wait-stop bits, loop control register and clock-failure response of the clock generator
// assumes mode, upper clock-select and self-clock status come from same-clock logic;
// clock failure and vco-near-target come from the analog side and are synchronised here
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - core clock is gated in wait mode when core_wait_stop is set
// - tick_wait_stop set halts tick timer and clears its dividers in wait
// - watchdog_wait_stop halts watchdog in wait; write once normal, anytime special
// - clock_monitor_enable enables loss detection; writes ignored while self-clock status set
// - full stop without pseudo-stop disables monitor and reports no clock loss
// - loop_power_on switches loop; writes ignored while loop_clock_select is set
// - self-clock mode forces loop on; reads still return latched power bit
// - powered loop with automatic bandwidth locks without software action
// - automatic bandwidth picks filter from vco nearness; else acquisition bit decides
// - loop_wait_stop holds automatic bandwidth at one and ignores writes to it
// - manual control: acquisition_select one is high bandwidth, zero is low
// - pseudo-stop tick enable clear freezes tick dividers without clearing them
// - pseudo-stop watchdog enable clear freezes watchdog dividers without clearing them
// - self_clock_enable write once normal; clearing refused while self-clock status set
// - clock failure enters self-clock mode if enabled, else monitor reset
// - self-clock mode requests loop minimum frequency on o_self_clock_min_freq
// - loop_wait_stop clears loop clock select for wait and powers loop down
module pll_wait_clock_monitor_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [pll_wait_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pll_wait_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pll_wait_pkg::DATA_W-1:0] o_rdata,
  input wire pll_wait_pkg::chip_mode_type i_mode,
  input wire pll_wait_pkg::clock_select_high_type i_clock_select_low_high,
  input wire logic i_self_clock_status,
  input wire logic i_clock_fail_async,
  input wire logic i_vco_near_async,
  output pll_wait_pkg::stop_ctrl_type o_stop_ctrl,
  output logic o_loop_power,
  output logic o_loop_auto_lock,
  output logic o_high_bandwidth,
  output logic o_monitor_active,
  output logic o_loss_of_clock,
  output logic o_self_clock_req,
  output logic o_monitor_reset_req,
  output logic o_loop_select_clear,
  output logic o_self_clock_min_freq
);
  import pll_wait_pkg::*;

  logic wr_clock_select_low, wr_loop, clock_fail, vco_near;
  logic pseudo_stop, full_stop, monitor_on, fail_rise;
  logic core_wait_stop_q, core_wait_stop_d;
  logic tick_wait_stop_q, tick_wait_stop_d;
  logic watchdog_wait_stop, watchdog_used;
  logic clock_monitor_enable_q, clock_monitor_enable_d;
  logic loop_power_on_q, loop_power_on_d;
  logic auto_bandwidth_q, auto_bandwidth_d;
  logic acquisition_select_q, acquisition_select_d;
  logic pseudo_stop_tick_enable_q, pseudo_stop_tick_enable_d;
  logic pseudo_stop_watchdog_enable_q, pseudo_stop_watchdog_enable_d;
  logic self_clock_enable, self_clock_used;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  stop_ctrl_type stop_q, stop_d;
  logic loop_power_q, loop_power_d;
  logic auto_lock_q, auto_lock_d;
  logic high_bw_q, high_bw_d;
  logic monitor_active_q, monitor_active_d;
  logic loss_q, loss_d;
  logic select_clear_q, select_clear_d;
  logic min_freq_q, min_freq_d;
  monitor_state_type mon_state_q, mon_state_d;
  logic fail_prev_q;
  logic self_req_q, self_req_d;
  logic mon_reset_q, mon_reset_d;

  input_sync3 u_fail_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_clock_fail_async),
    .o_level(clock_fail)
  );

  input_sync3 u_near_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_vco_near_async),
    .o_level(vco_near)
  );

  assign wr_clock_select_low = i_wr && (i_addr == CLOCK_SELECT_LOW_OFFSET);
  assign wr_loop = i_wr && (i_addr == LOOP_CONTROL_OFFSET);

  write_once_bit #(
    .RESET_VALUE(CLOCK_SELECT_LOW_RESET[WATCHDOG_WAIT_STOP_BIT])
  ) u_watchdog_wait_stop (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_write(wr_clock_select_low),
    .i_special(i_mode.special_mode),
    .i_refuse(1'b0),
    .i_value(i_wdata[WATCHDOG_WAIT_STOP_BIT]),
    .o_value(watchdog_wait_stop),
    .o_used(watchdog_used)
  );

  write_once_bit #(
    .RESET_VALUE(LOOP_CONTROL_RESET[SELF_CLOCK_ENABLE_BIT])
  ) u_self_clock_enable (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_write(wr_loop),
    .i_special(i_mode.special_mode),
    .i_refuse(i_self_clock_status && !i_wdata[SELF_CLOCK_ENABLE_BIT]),
    .i_value(i_wdata[SELF_CLOCK_ENABLE_BIT]),
    .o_value(self_clock_enable),
    .o_used(self_clock_used)
  );

  // register file: each bit keeps its own write condition
  always_comb begin
    core_wait_stop_d = core_wait_stop_q;
    tick_wait_stop_d = tick_wait_stop_q;
    clock_monitor_enable_d = clock_monitor_enable_q;
    loop_power_on_d = loop_power_on_q;
    auto_bandwidth_d = auto_bandwidth_q;
    acquisition_select_d = acquisition_select_q;
    pseudo_stop_tick_enable_d = pseudo_stop_tick_enable_q;
    pseudo_stop_watchdog_enable_d = pseudo_stop_watchdog_enable_q;
    if (wr_clock_select_low) begin
      core_wait_stop_d = i_wdata[CORE_WAIT_STOP_BIT];
      tick_wait_stop_d = i_wdata[TICK_WAIT_STOP_BIT];
    end
    if (wr_loop) begin
      if (!i_self_clock_status) begin
        clock_monitor_enable_d = i_wdata[CLOCK_MONITOR_ENABLE_BIT];
      end
      if (!i_clock_select_low_high.loop_clock_select) begin
        loop_power_on_d = i_wdata[LOOP_POWER_ON_BIT];
      end
      auto_bandwidth_d = i_wdata[AUTO_BANDWIDTH_BIT];
      acquisition_select_d = i_wdata[ACQUISITION_SELECT_BIT];
      pseudo_stop_tick_enable_d = i_wdata[PSEUDO_STOP_TICK_ENABLE_BIT];
      pseudo_stop_watchdog_enable_d = i_wdata[PSEUDO_STOP_WATCHDOG_ENABLE_BIT];
    end
    if (i_clock_select_low_high.loop_wait_stop) begin
      auto_bandwidth_d = 1'b1;
    end
  end

  // read data stand in the cycle after the read strobe only; latched power bit is shown
  always_comb begin
    rdata_d = READ_ZERO;
    if (i_rd && (i_addr == CLOCK_SELECT_LOW_OFFSET)) begin
      rdata_d[LOOP_CLOCK_SELECT_BIT] = i_clock_select_low_high.loop_clock_select;
      rdata_d[PSEUDO_STOP_SELECT_BIT] = i_clock_select_low_high.pseudo_stop_select;
      rdata_d[SYS_WAIT_STOP_BIT] = i_clock_select_low_high.sys_wait_stop;
      rdata_d[OSC_REDUCED_WAIT_BIT] = i_clock_select_low_high.osc_reduced_wait;
      rdata_d[LOOP_WAIT_STOP_BIT] = i_clock_select_low_high.loop_wait_stop;
      rdata_d[CORE_WAIT_STOP_BIT] = core_wait_stop_q;
      rdata_d[TICK_WAIT_STOP_BIT] = tick_wait_stop_q;
      rdata_d[WATCHDOG_WAIT_STOP_BIT] = watchdog_wait_stop;
    end else if (i_rd && (i_addr == LOOP_CONTROL_OFFSET)) begin
      rdata_d[CLOCK_MONITOR_ENABLE_BIT] = clock_monitor_enable_q;
      rdata_d[LOOP_POWER_ON_BIT] = loop_power_on_q;
      rdata_d[AUTO_BANDWIDTH_BIT] = auto_bandwidth_q;
      rdata_d[ACQUISITION_SELECT_BIT] = acquisition_select_q;
      rdata_d[PSEUDO_STOP_TICK_ENABLE_BIT] = pseudo_stop_tick_enable_q;
      rdata_d[PSEUDO_STOP_WATCHDOG_ENABLE_BIT] = pseudo_stop_watchdog_enable_q;
      rdata_d[SELF_CLOCK_ENABLE_BIT] = self_clock_enable;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      core_wait_stop_q <= CLOCK_SELECT_LOW_RESET[CORE_WAIT_STOP_BIT];
      tick_wait_stop_q <= CLOCK_SELECT_LOW_RESET[TICK_WAIT_STOP_BIT];
      clock_monitor_enable_q <= LOOP_CONTROL_RESET[CLOCK_MONITOR_ENABLE_BIT];
      loop_power_on_q <= LOOP_CONTROL_RESET[LOOP_POWER_ON_BIT];
      auto_bandwidth_q <= LOOP_CONTROL_RESET[AUTO_BANDWIDTH_BIT];
      acquisition_select_q <= LOOP_CONTROL_RESET[ACQUISITION_SELECT_BIT];
      pseudo_stop_tick_enable_q <= LOOP_CONTROL_RESET[PSEUDO_STOP_TICK_ENABLE_BIT];
      pseudo_stop_watchdog_enable_q <= LOOP_CONTROL_RESET[PSEUDO_STOP_WATCHDOG_ENABLE_BIT];
      rdata_q <= READ_ZERO;
    end else begin
      core_wait_stop_q <= core_wait_stop_d;
      tick_wait_stop_q <= tick_wait_stop_d;
      clock_monitor_enable_q <= clock_monitor_enable_d;
      loop_power_on_q <= loop_power_on_d;
      auto_bandwidth_q <= auto_bandwidth_d;
      acquisition_select_q <= acquisition_select_d;
      pseudo_stop_tick_enable_q <= pseudo_stop_tick_enable_d;
      pseudo_stop_watchdog_enable_q <= pseudo_stop_watchdog_enable_d;
      rdata_q <= rdata_d;
    end
  end

  assign pseudo_stop = i_mode.stop_mode && i_clock_select_low_high.pseudo_stop_select;
  assign full_stop = i_mode.stop_mode && !i_clock_select_low_high.pseudo_stop_select;
  assign monitor_on = clock_monitor_enable_q && !full_stop;
  assign fail_rise = clock_fail && !fail_prev_q;

  // control outputs, all registered so they never glitch into the clock gates
  always_comb begin
    stop_d.core_clock_gate = i_mode.wait_mode && core_wait_stop_q;
    stop_d.tick_div_clear = i_mode.wait_mode && tick_wait_stop_q;
    stop_d.tick_run = !stop_d.tick_div_clear && !(pseudo_stop && !pseudo_stop_tick_enable_q);
    stop_d.watchdog_div_clear = i_mode.wait_mode && watchdog_wait_stop;
    stop_d.watchdog_run = !stop_d.watchdog_div_clear && !(pseudo_stop && !pseudo_stop_watchdog_enable_q);
    select_clear_d = i_mode.wait_mode && i_clock_select_low_high.loop_wait_stop;
    // power bit stays latched; the loop itself drops in wait with loop_wait_stop set and is forced on in self-clock
    loop_power_d = i_self_clock_status || (loop_power_on_q && !select_clear_d);
    auto_lock_d = loop_power_d && auto_bandwidth_q;
    high_bw_d = auto_bandwidth_q ? !vco_near : acquisition_select_q;
    monitor_active_d = monitor_on;
    loss_d = monitor_on && clock_fail;
    min_freq_d = i_self_clock_status;
  end

  // one response per failure; the monitor rearms once the failure clears
  always_comb begin
    mon_state_d = mon_state_q;
    self_req_d = 1'b0;
    mon_reset_d = 1'b0;
    unique case (mon_state_q)
      MON_IDLE: begin
        if (fail_rise && monitor_on) begin
          self_req_d = self_clock_enable;
          mon_reset_d = !self_clock_enable;
          mon_state_d = MON_HANDLED;
        end
      end
      MON_HANDLED: begin
        if (!clock_fail) begin
          mon_state_d = MON_IDLE;
        end
      end
      default: begin
        mon_state_d = MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_q <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      loop_power_q <= 1'b0;
      auto_lock_q <= 1'b0;
      high_bw_q <= 1'b0;
      monitor_active_q <= 1'b0;
      loss_q <= 1'b0;
      select_clear_q <= 1'b0;
      min_freq_q <= 1'b0;
      mon_state_q <= MON_IDLE;
      fail_prev_q <= 1'b0;
      self_req_q <= 1'b0;
      mon_reset_q <= 1'b0;
    end else begin
      stop_q <= stop_d;
      loop_power_q <= loop_power_d;
      auto_lock_q <= auto_lock_d;
      high_bw_q <= high_bw_d;
      monitor_active_q <= monitor_active_d;
      loss_q <= loss_d;
      select_clear_q <= select_clear_d;
      min_freq_q <= min_freq_d;
      mon_state_q <= mon_state_d;
      fail_prev_q <= clock_fail;
      self_req_q <= self_req_d;
      mon_reset_q <= mon_reset_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_stop_ctrl = stop_q;
  assign o_loop_power = loop_power_q;
  assign o_loop_auto_lock = auto_lock_q;
  assign o_high_bandwidth = high_bw_q;
  assign o_monitor_active = monitor_active_q;
  assign o_loss_of_clock = loss_q;
  assign o_self_clock_req = self_req_q;
  assign o_monitor_reset_req = mon_reset_q;
  assign o_loop_select_clear = select_clear_q;
  assign o_self_clock_min_freq = min_freq_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_core_gate;
    i_mode.wait_mode && core_wait_stop_q |=> o_stop_ctrl.core_clock_gate;
  endproperty
  a_core_gate: assert property (p_core_gate) else $error("core clock not gated in wait");
  property p_tick_wait;
    i_mode.wait_mode && tick_wait_stop_q |=> o_stop_ctrl.tick_div_clear && !o_stop_ctrl.tick_run;
  endproperty
  a_tick_wait: assert property (p_tick_wait) else $error("tick timer not halted in wait");
  property p_watchdog_once;
    wr_clock_select_low && !i_mode.special_mode && watchdog_used |=> $stable(watchdog_wait_stop);
  endproperty
  a_watchdog_once: assert property (p_watchdog_once) else $error("watchdog stop bit took second write");
  property p_monitor_locked;
    wr_loop && i_self_clock_status |=> $stable(clock_monitor_enable_q);
  endproperty
  a_monitor_locked: assert property (p_monitor_locked) else $error("monitor enable changed in self-clock");
  property p_full_stop;
    full_stop |=> !o_monitor_active && !o_loss_of_clock;
  endproperty
  a_full_stop: assert property (p_full_stop) else $error("monitor active in full stop");
  property p_power_locked;
    wr_loop && i_clock_select_low_high.loop_clock_select |=> $stable(loop_power_on_q);
  endproperty
  a_power_locked: assert property (p_power_locked) else $error("power bit written while loop selected");
  property p_self_clock_power;
    i_self_clock_status |=> o_loop_power;
  endproperty
  a_self_clock_power: assert property (p_self_clock_power) else $error("loop not forced on in self-clock");
  property p_auto_held;
    i_clock_select_low_high.loop_wait_stop |=> auto_bandwidth_q;
  endproperty
  a_auto_held: assert property (p_auto_held) else $error("auto bandwidth not held");
  property p_tick_freeze;
    pseudo_stop && !pseudo_stop_tick_enable_q && !i_mode.wait_mode |=>
      !o_stop_ctrl.tick_run && !o_stop_ctrl.tick_div_clear;
  endproperty
  a_tick_freeze: assert property (p_tick_freeze) else $error("tick dividers not frozen");
  property p_fail_response;
    mon_state_q == MON_IDLE && fail_rise && monitor_on |=>
      (o_self_clock_req == self_clock_enable) && (o_monitor_reset_req != self_clock_enable) ##1
      !o_self_clock_req && !o_monitor_reset_req;
  endproperty
  a_fail_response: assert property (p_fail_response) else $error("wrong clock failure response");
  c_self_clock: cover property (o_self_clock_req);
  c_monitor_reset: cover property (o_monitor_reset_req);
  c_once_refused: cover property (wr_clock_select_low && !i_mode.special_mode && watchdog_used);
  c_wait_loop_down: cover property (o_loop_select_clear && loop_power_on_q);

endmodule : pll_wait_clock_monitor_ctrl
`default_nettype wire

//--- hdl/pll_wait_pkg.sv
// constants, field positions and carrier types for the loop and wait-stop control block
// assumes an 8-bit register port on the bus clock and a single synchronous clock domain
package pll_wait_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] CLOCK_SELECT_LOW_OFFSET = 8'h05;
  localparam logic [ADDR_W-1:0] LOOP_CONTROL_OFFSET = 8'h06;

  // clock_select_low fields
  localparam int LOOP_CLOCK_SELECT_BIT = 7;
  localparam int PSEUDO_STOP_SELECT_BIT = 6;
  localparam int SYS_WAIT_STOP_BIT = 5;
  localparam int OSC_REDUCED_WAIT_BIT = 4;
  localparam int LOOP_WAIT_STOP_BIT = 3;
  localparam int CORE_WAIT_STOP_BIT = 2;
  localparam int TICK_WAIT_STOP_BIT = 1;
  localparam int WATCHDOG_WAIT_STOP_BIT = 0;

  // loop_control fields
  localparam int CLOCK_MONITOR_ENABLE_BIT = 7;
  localparam int LOOP_POWER_ON_BIT = 6;
  localparam int AUTO_BANDWIDTH_BIT = 5;
  localparam int ACQUISITION_SELECT_BIT = 4;
  localparam int PSEUDO_STOP_TICK_ENABLE_BIT = 2;
  localparam int PSEUDO_STOP_WATCHDOG_ENABLE_BIT = 1;
  localparam int SELF_CLOCK_ENABLE_BIT = 0;

  localparam logic [DATA_W-1:0] CLOCK_SELECT_LOW_RESET = 8'h00;
  localparam logic [DATA_W-1:0] LOOP_CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  typedef struct packed {
    logic wait_mode;
    logic stop_mode;
    logic special_mode;
  } chip_mode_type;

  // upper clock-select bits live elsewhere and arrive as levels
  typedef struct packed {
    logic loop_clock_select;
    logic pseudo_stop_select;
    logic sys_wait_stop;
    logic osc_reduced_wait;
    logic loop_wait_stop;
  } clock_select_high_type;

  typedef struct packed {
    logic core_clock_gate;
    logic tick_run;
    logic tick_div_clear;
    logic watchdog_run;
    logic watchdog_div_clear;
  } stop_ctrl_type;

  typedef enum logic [1:0] {
    MON_IDLE,
    MON_HANDLED
  } monitor_state_type;

endpackage : pll_wait_pkg

//--- hdl/write_once_bit.sv
// one control bit that takes a single write in normal modes and any write in special modes
// assumes the caller decodes the register write and any refusal condition
`timescale 1ns/100ps
`default_nettype none
module write_once_bit #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_write,
  input wire logic i_special,
  input wire logic i_refuse,
  input wire logic i_value,
  output logic o_value,
  output logic o_used
);

  logic value_q;
  logic value_d;
  logic used_q;
  logic used_d;

  // a refused write does not spend the single normal-mode write
  always_comb begin
    value_d = value_q;
    used_d = used_q;
    if (i_write && !i_refuse && (i_special || !used_q)) begin
      value_d = i_value;
      used_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      value_q <= RESET_VALUE;
      used_q <= 1'b0;
    end else begin
      value_q <= value_d;
      used_q <= used_d;
    end
  end

  assign o_value = value_q;
  assign o_used = used_q;

endmodule : write_once_bit
`default_nettype wire

//--- testbench/pll_wait_clock_monitor_ctrl_tb.sv
// bench for the loop control and wait-stop block: registers, stop controls, failure response
// assumes the bench drives every port itself; registers are reached over the strobe port
`timescale 1ns/100ps
`default_nettype none
module pll_wait_clock_monitor_ctrl_tb;
  import pll_wait_pkg::*;
  logic clk, rst_b, wr, rd, scs, fail, near;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  chip_mode_type mode;
  clock_select_high_type csh;
  stop_ctrl_type stop;
  logic pwr, alock, hbw, mon, loss, screq, mrreq, lsc, minf;
  int fail_count = 0;
  int compares = 0;

  pll_wait_clock_monitor_ctrl dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_mode(mode), .i_clock_select_low_high(csh), .i_self_clock_status(scs),
    .i_clock_fail_async(fail), .i_vco_near_async(near), .o_stop_ctrl(stop), .o_loop_power(pwr),
    .o_loop_auto_lock(alock), .o_high_bandwidth(hbw), .o_monitor_active(mon), .o_loss_of_clock(loss),
    .o_self_clock_req(screq), .o_monitor_reset_req(mrreq), .o_loop_select_clear(lsc),
    .o_self_clock_min_freq(minf));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("rd%h", a), exp, rdata);
  endtask : rd_reg

  task automatic do_reset();
    rst_b <= 1'b0;
    settle(3);
    rst_b <= 1'b1;
    settle(1);
  endtask : do_reset

  // counts request pulses over a window longer than the synchroniser delay
  task automatic pulses(input logic [7:0] es, input logic [7:0] er);
    logic [7:0] ns;
    logic [7:0] nr;
    ns = 8'h00;
    nr = 8'h00;
    repeat (10) begin
      settle(1);
      ns = ns + 8'(screq === 1'b1);
      nr = nr + 8'(mrreq === 1'b1);
    end
    chk("screq", es, ns);
    chk("mrreq", er, nr);
  endtask : pulses

  task automatic t_reset();
    chk("stop", 8'h0A, 8'(stop));
    rd_reg(8'h05, 8'h40);
    settle(1);
    chk("rdata", 8'h00, rdata);
    rd_reg(8'h06, 8'h00);
  endtask : t_reset

  task automatic t_wait();
    wr_reg(8'h05, 8'hFF);
    rd_reg(8'h05, 8'h47);
    wr_reg(8'h05, 8'h00);
    rd_reg(8'h05, 8'h41);
    wr_reg(8'h07, 8'hFF);
    rd_reg(8'h07, 8'h00);
    mode.special_mode <= 1'b1;
    wr_reg(8'h05, 8'h06);
    rd_reg(8'h05, 8'h46);
    mode.wait_mode <= 1'b1;
    settle(2);
    chk("stop", 8'h16, 8'(stop));
    wr_reg(8'h05, 8'h01);
    settle(2);
    chk("stop", 8'h09, 8'(stop));
    mode.wait_mode <= 1'b0;
  endtask : t_wait

  task automatic t_loop();
    mode <= '0;
    do_reset();
    wr_reg(8'h06, 8'h41);
    wr_reg(8'h06, 8'h40);
    rd_reg(8'h06, 8'h41);
    chk("pwr", 8'h01, 8'(pwr));
    scs <= 1'b1;
    settle(2);
    chk("minf", 8'h01, 8'(minf));
    mode.special_mode <= 1'b1;
    wr_reg(8'h06, 8'h40);
    rd_reg(8'h06, 8'h41);
    wr_reg(8'h06, 8'hC1);
    rd_reg(8'h06, 8'h41);
    scs <= 1'b0;
    wr_reg(8'h06, 8'h01);
    settle(2);
    chk("pwr", 8'h00, 8'(pwr));
    scs <= 1'b1;
    settle(2);
    chk("pwr", 8'h01, 8'(pwr));
    rd_reg(8'h06, 8'h01);
    scs <= 1'b0;
    csh.loop_clock_select <= 1'b1;
    wr_reg(8'h06, 8'h41);
    rd_reg(8'h06, 8'h01);
    csh.loop_clock_select <= 1'b0;
    wr_reg(8'h06, 8'h60);
    settle(2);
    chk("alock", 8'h01, 8'(alock));
    chk("hbw", 8'h01, 8'(hbw));
    near <= 1'b1;
    wr_reg(8'h06, 8'h70);
    settle(6);
    chk("hbw", 8'h00, 8'(hbw));
    wr_reg(8'h06, 8'h50);
    settle(2);
    chk("hbw", 8'h01, 8'(hbw));
    chk("alock", 8'h00, 8'(alock));
    wr_reg(8'h06, 8'h40);
    settle(2);
    chk("hbw", 8'h00, 8'(hbw));
    csh.loop_wait_stop <= 1'b1;
    wr_reg(8'h06, 8'h40);
    rd_reg(8'h06, 8'h60);
    mode.wait_mode <= 1'b1;
    settle(2);
    chk("lsc", 8'h01, 8'(lsc));
    chk("pwr", 8'h00, 8'(pwr));
    rd_reg(8'h06, 8'h60);
    mode.wait_mode <= 1'b0;
    csh.loop_wait_stop <= 1'b0;
  endtask : t_loop

  task automatic t_pseudo();
    wr_reg(8'h06, 8'h00);
    mode.stop_mode <= 1'b1;
    settle(2);
    chk("stop", 8'h00, 8'(stop));
    wr_reg(8'h06, 8'h06);
    settle(2);
    chk("stop", 8'h0A, 8'(stop));
    mode.stop_mode <= 1'b0;
  endtask : t_pseudo

  task automatic t_fail();
    wr_reg(8'h06, 8'h81);
    settle(2);
    chk("mon", 8'h01, 8'(mon));
    fail <= 1'b1;
    pulses(8'h01, 8'h00);
    chk("loss", 8'h01, 8'(loss));
    fail <= 1'b0;
    settle(6);
    wr_reg(8'h06, 8'h80);
    fail <= 1'b1;
    pulses(8'h00, 8'h01);
    csh.pseudo_stop_select <= 1'b0;
    mode.stop_mode <= 1'b1;
    settle(2);
    chk("mon", 8'h00, 8'(mon));
    chk("loss", 8'h00, 8'(loss));
  endtask : t_fail

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    mode = '0;
    csh = clock_select_high_type'(5'b01000);
    scs = 1'b0;
    fail = 1'b0;
    near = 1'b0;
    do_reset();
    t_reset();
    t_wait();
    t_loop();
    t_pseudo();
    t_fail();
    summarize();
  end

  // the tests need about 130 cycles; 5000 leaves wide margin for a stuck handshake
  initial begin
    #125000;
    fail_count++;
    summarize();
  end
endmodule : pll_wait_clock_monitor_ctrl_tb
`default_nettype wire
